// ==== pkg/tsw_consts.svh ====
// Purpose: offsets, fields and values of the triangle walker
// Assumes: 32-bit register port, byte offsets on word boundaries
// Notes: included by the pack module, the top module and the bench
// Function
// [R1] cull bit set: reject triangles by area sign, sign chosen by draw bit
// [R2] colour-order bit picks ABGR (0) or ARGB (1), eight bits each
// [R3] host writes zero into every unused setup-mode bit
// [R4] repeat uses the setup mode latched at the matching draw
// [R5] host keeps both start-coordinate offset bits zero when setup is used
// [R6] dominant side spans most Y; either side for flat tops or bottoms
// [R7] every span starts at the dominant edge and runs toward the subordinate
// [R8] each row adds dominant slope to start X, subordinate slope to end X
// [R9] non-flat-topped triangle: host loads equal dominant and subordinate start X
// [R10] lower half: host reloads subordinate start X, slope and row count
// [R11] raster mode settings persist until rewritten, for every primitive
// [R12] centering on: interpolated values are sampled at fragment centres
// [R13] host picks centering per primitive in the render command
// [R14] depth values are a register pair: integer upper, fraction lower
// [R15] after a render is taken, edge registers may change without harm
// [R16] continue command starts the second sub-triangle with new subordinate values
// [R17] start X, start Y, slopes and row step are 16.16 fixed point
// [R18] colour adds edge step per row, span step per fragment
// [R19] shaded triangle: host clears render fields except shape and centering
// [R20] rows step down or up by the sign of the row step
// [R21] a culled triangle yields no fragments and issues no render
// [R22] setup-mode bits 3:2 pick depth width: 0 is 15 bits, 1 is 16
`ifndef TSW_CONSTS_SVH
`define TSW_CONSTS_SVH
// ***********************************************************
// register offsets
// ***********************************************************
`define TSW_OFF_MODE 8'h00
`define TSW_OFF_RMODE 8'h04
`define TSW_OFF_DSX 8'h08
`define TSW_OFF_DSL 8'h0C
`define TSW_OFF_SSX 8'h10
`define TSW_OFF_SSL 8'h14
`define TSW_OFF_Y0 8'h18
`define TSW_OFF_YSTEP 8'h1C
`define TSW_OFF_CNT 8'h20
`define TSW_OFF_R0 8'h24
`define TSW_OFF_RDY 8'h28
`define TSW_OFF_RDX 8'h2C
`define TSW_OFF_ZSI 8'h30
`define TSW_OFF_ZSF 8'h34
`define TSW_OFF_ZDYI 8'h38
`define TSW_OFF_ZDYF 8'h3C
`define TSW_OFF_ZDXI 8'h40
`define TSW_OFF_ZDXF 8'h44
`define TSW_OFF_RENDER 8'h48
`define TSW_OFF_CONT 8'h4C
`define TSW_OFF_DRAW 8'h50
`define TSW_OFF_REPEAT 8'h54
`define TSW_OFF_AREA 8'h58
`define TSW_OFF_STATUS 8'h5C
// ***********************************************************
// fields and values
// ***********************************************************
`define TSW_MODE_MASK 32'h0007FFFC
`define TSW_MODE_CULL 17
`define TSW_MODE_ORDER 18
`define TSW_MODE_CENTER 10
`define TSW_MODE_ZSEL_HI 3
`define TSW_MODE_ZSEL_LO 2
`define TSW_ZSEL_15 2'h0
`define TSW_RM_BIAS_HI 5
`define TSW_RM_BIAS_LO 4
`define TSW_CMD_CENTER 16
`define TSW_CMD_REJNEG 20
`define TSW_HALF 32'h00008000
`define TSW_ALPHA_ONE 8'hFF
`endif

// ==== pkg/tsw_pkg.sv ====
// Purpose: types of the triangle walker
// Assumes: constants come from tsw_consts.svh
// Notes: the whole walker state is one packed struct
package tsw_pkg;
   typedef enum logic [1:0] {
      TSW_IDLE = 2'b00,
      TSW_ROW = 2'b01,
      TSW_SPAN = 2'b10,
      TSW_ADV = 2'b11
   } tsw_state_t;

   typedef struct packed {
      tsw_state_t st;
      logic [31:0] mode, rmode, dsx, dsl, ssx, ssl, y0, ystep, cnt;
      logic [31:0] r0, rdy, rdx, zsi, zsf, zdyi, zdyf, zdxi, zdxf, area, snap_mode;
      logic [31:0] wmode, wxd, wxs, wdsl, wssl, wy, wys, wcnt, wr, wrdy, wrdx;
      logic [63:0] wz, wzdy, wzdx, fz;
      logic [31:0] fr, csx, csl, ccnt;
      logic [15:0] fx, fend, culls;
      logic ltr, cen, cpend, fvalid, ocen, issue;
      logic [15:0] ox, oy;
      logic [31:0] ocol, oz, rdata;
   } tsw_regs_t;
endpackage

// ==== hw/tsw_rst_sync.sv ====
// Purpose: releases the asynchronous reset through two flip-flops
// Assumes: rst_n low is reset
// Notes: assertion is immediate, release is synchronous
`timescale 1ns/1ns
module tsw_rst_sync (
   input wire logic clk,
   input wire logic rst_n,
   output logic rst_sync_n
);
   logic [1:0] sync_q;

   // constant shifted in, so the flops never sample a port under reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_q <= 2'h0;
      end else begin
         sync_q <= {sync_q[0], 1'b1};
      end
   end

   assign rst_sync_n = sync_q[1];
endmodule // tsw_rst_sync

// ==== hw/tsw_pack.sv ====
// Purpose: packs a fragment colour and trims its depth
// Assumes: red is 8.16 fixed point, depth integer in the upper word
// Notes: combinational; the top module registers the results
`timescale 1ns/1ns
`include "tsw_consts.svh"
module tsw_pack (
   input wire logic [31:0] red_fix,
   input wire logic color_order,
   input wire logic [31:0] z_int,
   input wire logic [1:0] z_width_sel,
   output logic [31:0] packed_color,
   output logic [31:0] depth_out
);
   logic [7:0] red_byte;

   // component order; green and blue are not interpolated here
   always_comb begin
      red_byte = red_fix[23:16];
      if (color_order) begin
         packed_color = {`TSW_ALPHA_ONE, red_byte, 16'h0000}; // [R2]
      end else begin
         packed_color = {`TSW_ALPHA_ONE, 16'h0000, red_byte}; // [R2]
      end
   end

   // reserved width codes fall back to 16 bits
   always_comb begin
      if (z_width_sel == `TSW_ZSEL_15) begin
         depth_out = {17'h00000, z_int[14:0]}; // [R22]
      end else begin
         depth_out = {16'h0000, z_int[15:0]}; // [R22]
      end
   end
endmodule // tsw_pack

// ==== hw/tsw_top.sv ====
// Purpose: triangle setup options and edge-walking span rasterizer
// Assumes: host waits for busy low before a new render, draw or repeat
// Notes: one fragment per cycle, no back-pressure from downstream
`timescale 1ns/1ns
`include "tsw_consts.svh"
module tsw_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic frag_valid,
   output logic [15:0] frag_x,
   output logic [15:0] frag_y,
   output logic [31:0] frag_color,
   output logic [31:0] frag_depth,
   output logic frag_centered,
   output logic render_issue,
   output logic busy
);
   // ***********************************************************
   // helpers
   // ***********************************************************
   function automatic logic [31:0] half32(input logic [31:0] v);
      half32 = {v[31], v[31:1]};
   endfunction

   function automatic logic [63:0] half64(input logic [63:0] v);
      half64 = {v[63], v[63:1]};
   endfunction

   function automatic logic [31:0] step32(input logic [31:0] a, input logic [31:0] b,
                                          input logic neg);
      step32 = neg ? a - b : a + b;
   endfunction

   function automatic logic [63:0] step64(input logic [63:0] a, input logic [63:0] b,
                                          input logic neg);
      step64 = neg ? a - b : a + b;
   endfunction

   // ***********************************************************
   // reset and state
   // ***********************************************************
   logic rst_q_n;
   tsw_pkg::tsw_regs_t q, d;
   logic [31:0] pack_col, pack_z;
   logic [15:0] xdi, xsi, nfx;
   logic start_go, start_center, area_neg, area_pos, culled;
   logic [31:0] start_mode, start_cmd, bias;

   tsw_rst_sync u_rst (
      .clk(clk),
      .rst_n(rst_n),
      .rst_sync_n(rst_q_n)
   );

   tsw_pack u_pack (
      .red_fix(q.fr),
      .color_order(q.wmode[`TSW_MODE_ORDER]),
      .z_int(q.fz[63:32]),
      .z_width_sel(q.wmode[`TSW_MODE_ZSEL_HI:`TSW_MODE_ZSEL_LO]),
      .packed_color(pack_col),
      .depth_out(pack_z)
   );

   assign area_neg = q.area[31];
   assign area_pos = !q.area[31] && (q.area != 32'h00000000);

   // ***********************************************************
   // next state
   // ***********************************************************
   always_comb begin
      d = q;
      d.fvalid = 1'b0;
      d.issue = 1'b0;
      d.rdata = 32'h00000000;
      start_go = 1'b0;
      start_center = 1'b0;
      start_mode = q.mode;
      start_cmd = 32'h00000000;
      culled = 1'b0;
      xdi = q.wxd[31:16]; // [R17]
      xsi = q.wxs[31:16];
      nfx = q.ltr ? q.fx + 16'h0001 : q.fx - 16'h0001;
      bias = (q.rmode[`TSW_RM_BIAS_HI:`TSW_RM_BIAS_LO] != 2'h0) ? `TSW_HALF : 32'h00000000;

      // edge walker; uses only working copies
      case (q.st)
         tsw_pkg::TSW_ROW: begin
            // direction from the dominant edge toward the subordinate one
            d.ltr = $signed(xdi) <= $signed(xsi); // [R6] [R7]
            d.fx = d.ltr ? xdi : xdi - 16'h0001; // [R7]
            d.fend = d.ltr ? xsi : xsi - 16'h0001; // right-hand pixel left out
            d.fr = step32(q.wr, q.cen ? half32(q.wrdx) : 32'h00000000, !d.ltr); // [R12]
            d.fz = step64(q.wz, q.cen ? half64(q.wzdx) : 64'h0, !d.ltr); // [R12]
            d.st = (d.fx == d.fend) ? tsw_pkg::TSW_ADV : tsw_pkg::TSW_SPAN;
         end
         tsw_pkg::TSW_SPAN: begin
            d.fvalid = 1'b1;
            d.ox = q.fx;
            d.oy = q.wy[31:16];
            d.ocol = pack_col;
            d.oz = pack_z;
            d.ocen = q.cen;
            d.fx = nfx;
            d.fr = step32(q.fr, q.wrdx, !q.ltr); // [R18]
            d.fz = step64(q.fz, q.wzdx, !q.ltr);
            if (nfx == q.fend) begin
               d.st = tsw_pkg::TSW_ADV;
            end
         end
         tsw_pkg::TSW_ADV: begin
            // next scanline: both edges, Y and the row start values
            d.wxd = q.wxd + q.wdsl; // [R8]
            d.wxs = q.wxs + q.wssl; // [R8]
            d.wy = q.wy + q.wys; // [R20]
            d.wr = q.wr + q.wrdy; // [R18]
            d.wz = q.wz + q.wzdy;
            d.wcnt = q.wcnt - 32'h00000001;
            d.st = tsw_pkg::TSW_ROW;
            if (d.wcnt == 32'h00000000) begin
               if (q.cpend) begin
                  // dominant edge walks on, subordinate edge is replaced
                  d.wxs = q.csx; // [R16] [R10]
                  d.wssl = q.csl; // [R16]
                  d.wcnt = q.ccnt;
                  d.cpend = 1'b0;
                  d.st = (q.ccnt == 32'h00000000) ? tsw_pkg::TSW_IDLE : tsw_pkg::TSW_ROW;
               end else begin
                  d.st = tsw_pkg::TSW_IDLE;
               end
            end
         end
         default: begin
            d.st = tsw_pkg::TSW_IDLE;
         end
      endcase

      // register writes; programmed copies only, except a continue while idle loads the walker
      if (reg_wr) begin
         case (reg_addr)
            `TSW_OFF_MODE: d.mode = reg_wdata & `TSW_MODE_MASK; // [R3]
            `TSW_OFF_RMODE: d.rmode = reg_wdata; // [R11] [R5]
            `TSW_OFF_DSX: d.dsx = reg_wdata; // [R15] [R9]
            `TSW_OFF_DSL: d.dsl = reg_wdata;
            `TSW_OFF_SSX: d.ssx = reg_wdata; // [R15]
            `TSW_OFF_SSL: d.ssl = reg_wdata;
            `TSW_OFF_Y0: d.y0 = reg_wdata;
            `TSW_OFF_YSTEP: d.ystep = reg_wdata;
            `TSW_OFF_CNT: d.cnt = reg_wdata;
            `TSW_OFF_R0: d.r0 = reg_wdata;
            `TSW_OFF_RDY: d.rdy = reg_wdata;
            `TSW_OFF_RDX: d.rdx = reg_wdata;
            `TSW_OFF_ZSI: d.zsi = reg_wdata; // [R14]
            `TSW_OFF_ZSF: d.zsf = reg_wdata; // [R14]
            `TSW_OFF_ZDYI: d.zdyi = reg_wdata;
            `TSW_OFF_ZDYF: d.zdyf = reg_wdata;
            `TSW_OFF_ZDXI: d.zdxi = reg_wdata;
            `TSW_OFF_ZDXF: d.zdxf = reg_wdata;
            `TSW_OFF_AREA: d.area = reg_wdata;
            `TSW_OFF_RENDER: begin
               // direct render: no culling, current setup mode, centering from the command alone
               start_go = (q.st == tsw_pkg::TSW_IDLE);
               start_cmd = reg_wdata;
               start_center = reg_wdata[`TSW_CMD_CENTER]; // [R13] [R19]
            end
            `TSW_OFF_DRAW, `TSW_OFF_REPEAT: begin
               start_cmd = reg_wdata;
               if (reg_addr == `TSW_OFF_DRAW) begin
                  d.snap_mode = (q.st == tsw_pkg::TSW_IDLE) ? q.mode : q.snap_mode; // [R4]
               end else begin
                  start_mode = q.snap_mode; // [R4]
               end
               start_center = reg_wdata[`TSW_CMD_CENTER] && start_mode[`TSW_MODE_CENTER];
               culled = start_mode[`TSW_MODE_CULL] &&
                        (reg_wdata[`TSW_CMD_REJNEG] ? area_neg : area_pos); // [R1]
               start_go = (q.st == tsw_pkg::TSW_IDLE) && !culled; // [R21]
               if (culled && (q.st == tsw_pkg::TSW_IDLE)) begin
                  d.culls = q.culls + 16'h0001;
               end
            end
            `TSW_OFF_CONT: begin
               if (d.st == tsw_pkg::TSW_IDLE) begin
                  // first part already done: start the second at once
                  d.wxs = q.ssx; // [R16]
                  d.wssl = q.ssl;
                  d.wcnt = reg_wdata;
                  d.st = (reg_wdata == 32'h00000000) ? tsw_pkg::TSW_IDLE : tsw_pkg::TSW_ROW;
               end else begin
                  d.csx = q.ssx; // [R16] [R15]
                  d.csl = q.ssl;
                  d.ccnt = reg_wdata;
                  d.cpend = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end

      // primitive start: snapshot so later writes cannot disturb it
      if (start_go) begin
         d.wmode = start_mode;
         d.wxd = q.dsx + bias; // [R15] [R5]
         d.wxs = q.ssx + bias;
         d.wdsl = q.dsl;
         d.wssl = q.ssl;
         d.wy = q.y0 + bias;
         d.wys = q.ystep; // [R20]
         d.wcnt = q.cnt;
         d.wr = q.r0;
         d.wrdy = q.rdy;
         d.wrdx = q.rdx;
         d.wz = {q.zsi, q.zsf}; // [R14]
         d.wzdy = {q.zdyi, q.zdyf};
         d.wzdx = {q.zdxi, q.zdxf};
         d.cen = start_center;
         d.cpend = 1'b0;
         d.issue = 1'b1;
         d.st = (q.cnt == 32'h00000000) ? tsw_pkg::TSW_IDLE : tsw_pkg::TSW_ROW;
         if (q.cen == 1'b0 && start_cmd == 32'h00000000) begin
            d.cen = 1'b0;
         end
      end

      // read data valid the cycle after the strobe only
      if (reg_rd) begin
         case (reg_addr)
            `TSW_OFF_MODE: d.rdata = q.mode;
            `TSW_OFF_RMODE: d.rdata = q.rmode;
            `TSW_OFF_DSX: d.rdata = q.dsx;
            `TSW_OFF_DSL: d.rdata = q.dsl;
            `TSW_OFF_SSX: d.rdata = q.ssx;
            `TSW_OFF_SSL: d.rdata = q.ssl;
            `TSW_OFF_Y0: d.rdata = q.y0;
            `TSW_OFF_YSTEP: d.rdata = q.ystep;
            `TSW_OFF_CNT: d.rdata = q.cnt;
            `TSW_OFF_R0: d.rdata = q.r0;
            `TSW_OFF_RDY: d.rdata = q.rdy;
            `TSW_OFF_RDX: d.rdata = q.rdx;
            `TSW_OFF_ZSI: d.rdata = q.zsi;
            `TSW_OFF_ZSF: d.rdata = q.zsf;
            `TSW_OFF_ZDYI: d.rdata = q.zdyi;
            `TSW_OFF_ZDYF: d.rdata = q.zdyf;
            `TSW_OFF_ZDXI: d.rdata = q.zdxi;
            `TSW_OFF_ZDXF: d.rdata = q.zdxf;
            `TSW_OFF_AREA: d.rdata = q.area;
            `TSW_OFF_STATUS: d.rdata = {q.culls, 13'h0000, q.ltr, q.cpend,
                                        q.st != tsw_pkg::TSW_IDLE};
            default: d.rdata = 32'h00000000;
         endcase
      end
   end

   // ***********************************************************
   // state register
   // ***********************************************************
   always_ff @(posedge clk or negedge rst_q_n) begin
      if (!rst_q_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata = q.rdata;
   assign frag_valid = q.fvalid;
   assign frag_x = q.ox;
   assign frag_y = q.oy;
   assign frag_color = q.ocol;
   assign frag_depth = q.oz;
   assign frag_centered = q.ocen;
   assign render_issue = q.issue;
   assign busy = q.st != tsw_pkg::TSW_IDLE;

   // ***********************************************************
   // checks
   // ***********************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_q_n);

   logic draw_w, cull_hit;
   assign draw_w = reg_wr && (reg_addr == `TSW_OFF_DRAW) && !busy;
   assign cull_hit = q.mode[`TSW_MODE_CULL] &&
                     (reg_wdata[`TSW_CMD_REJNEG] ? area_neg : area_pos);

   cull_no_issue_a: assert property (draw_w && cull_hit |=> !render_issue ##1 !frag_valid) // [R21]
      else $error("culled triangle issued a render");
   cull_pass_a: assert property (draw_w && !cull_hit |=> render_issue) // [R1]
      else $error("unculled triangle was not issued");
   color_order_a: assert property (frag_valid && !q.wmode[`TSW_MODE_ORDER] // [R2]
                                   |-> frag_color[23:8] == 16'h0000)
      else $error("packed colour in wrong order");
   // a repeat culls by the snapshot mode, not by the current one
   repeat_snap_a: assert property (reg_wr && reg_addr == `TSW_OFF_REPEAT && !busy // [R4]
                                   && !(q.snap_mode[`TSW_MODE_CULL]
                                        && (reg_wdata[`TSW_CMD_REJNEG] ? area_neg : area_pos))
                                   |=> q.wmode == $past(q.snap_mode))
      else $error("repeat did not reuse draw setup mode");
   span_dir_a: assert property (frag_valid && $past(frag_valid) // [R7]
                                && frag_y == $past(frag_y)
                                |-> frag_x == (q.ltr ? $past(frag_x) + 16'h0001
                                                     : $past(frag_x) - 16'h0001))
      else $error("span not walked from dominant edge");
   row_step_a: assert property ($past(q.st) == tsw_pkg::TSW_ADV // [R8]
                                |-> q.wxd == $past(q.wxd) + $past(q.wdsl)
                                    && q.wy == $past(q.wy) + $past(q.wys))
      else $error("row advance wrong");
   cont_load_a: assert property ($past(q.cpend) && !q.cpend && busy // [R16]
                                 |-> q.wxs == $past(q.csx) && q.wssl == $past(q.csl))
      else $error("continue did not load new subordinate edge");
   shadow_hold_a: assert property (busy && reg_wr && reg_addr == `TSW_OFF_DSL // [R15]
                                   |=> q.wdsl == $past(q.wdsl))
      else $error("busy primitive disturbed by host write");
   rmode_keep_a: assert property (!(reg_wr && reg_addr == `TSW_OFF_RMODE) // [R11]
                                  |=> $stable(q.rmode))
      else $error("raster mode changed without a write");
   depth_width_a: assert property (frag_valid && q.wmode[3:2] == 2'h0 // [R22]
                                   |-> frag_depth[31:15] == 17'h00000)
      else $error("depth wider than 15 bits");

   draw_cov_c: cover property (render_issue ##[1:50] frag_valid);
   cull_cov_c: cover property (draw_w && cull_hit);
   cont_cov_c: cover property ($fell(q.cpend) && busy);
   rtl_cov_c: cover property (frag_valid && !q.ltr);
endmodule // tsw_top

// ==== tb/tsw_top_tb.sv ====
// Purpose: self-checking bench for the triangle walker top
// Assumes: host waits for busy low before each render, draw or repeat
// Notes: fragments are captured in walk order and compared with a model queue
`timescale 1ns/1ns
`include "tsw_consts.svh"
module tsw_top_tb;
   logic clk, rst_n, reg_wr, reg_rd, frag_valid, frag_centered, render_issue, busy, lc;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, frag_color, frag_depth, rd_v;
   logic [15:0] frag_x, frag_y;
   logic [63:0] fq[$], eq[$];
   logic [31:0] dq[$];
   // model edge state: y, ystep, dom x, dom slope, sub x, sub slope, red, red row, red span
   logic [31:0] m [9];
   logic [31:0] v [9];
   logic [7:0] offs [9];
   int failures, n_tests, ni;

   tsw_top i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frag_valid(frag_valid),
      .frag_x(frag_x), .frag_y(frag_y), .frag_color(frag_color), .frag_depth(frag_depth),
      .frag_centered(frag_centered), .render_issue(render_issue), .busy(busy));

   // ***********************************************************
   // clock and fragment capture
   // ***********************************************************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // outputs are registered, so the value before the edge is the settled one
   always @(posedge clk) begin
      if (frag_valid === 1'b1) begin
         fq.push_back({frag_y, frag_x, frag_color});
         dq.push_back(frag_depth);
         lc = frag_centered;
      end
      if (render_issue === 1'b1) ni++;
   end

   // ***********************************************************
   // bus tasks, model and comparison
   // ***********************************************************
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("counts: %0d compares, %0d mismatches", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the read edge
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
   endtask

   // bounded wait for idle, then a few cycles so the last fragment lands
   task automatic settle;
      int k;
      k = 0;
      do begin
         @(posedge clk);
         #1 k++;
      end while (busy !== 1'b0 && k < 500);
      if (k >= 500) begin
         failures++;
         test_done;
      end
      repeat (3) @(posedge clk);
   endtask

   task automatic edges(input logic [31:0] e [9]);
      foreach (e[i]) begin
         m[i] = e[i];
         wr(offs[i], e[i]);
      end
   endtask

   // expected spans: right-hand pixel left out, red steps along the walk direction
   task automatic walk(input int n, input logic ord, input logic cen);
      logic [31:0] rr;
      logic [15:0] x;
      logic ltr;
      repeat (n) begin
         ltr = $signed(m[2][31:16]) <= $signed(m[4][31:16]);
         rr = cen ? {m[8][31], m[8][31:1]} : 32'h0;
         rr = ltr ? m[6] + rr : m[6] - rr;
         x = m[2][31:16];
         while (x != m[4][31:16]) begin
            if (!ltr) x = x - 16'h1;
            eq.push_back({m[0][31:16], x,
               ord ? {8'hFF, rr[23:16], 16'h0} : {24'hFF0000, rr[23:16]}});
            if (ltr) x = x + 16'h1;
            rr = ltr ? rr + m[8] : rr - m[8];
         end
         m[0] = m[0] + m[1];
         m[2] = m[2] + m[3];
         m[4] = m[4] + m[5];
         m[6] = m[6] + m[7];
      end
   endtask

   task automatic cmpq(input string name);
      chk(64'(fq.size()), 64'(eq.size()));
      foreach (eq[i]) if (i < fq.size()) chk(fq[i], eq[i]);
      fq.delete();
      eq.delete();
      dq.delete();
      $display("test %s done", name);
   endtask

   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      failures = 0;
      n_tests = 0;
      ni = 0;
      lc = 1'b0;
      offs = '{`TSW_OFF_Y0, `TSW_OFF_YSTEP, `TSW_OFF_DSX, `TSW_OFF_DSL, `TSW_OFF_SSX,
         `TSW_OFF_SSL, `TSW_OFF_R0, `TSW_OFF_RDY, `TSW_OFF_RDX};
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      // register access: reserved mode bits and an unmapped place read zero
      wr(`TSW_OFF_MODE, 32'hFFFFFFFF);
      rd(`TSW_OFF_MODE);
      chk(rd_v, 32'h0007FFFC);
      rd(8'hF0);
      chk(rd_v, 32'h0);
      wr(`TSW_OFF_RMODE, 32'h0);
      wr(`TSW_OFF_MODE, 32'h0);
      $display("test registers done");
      // widening trapezoid walked down, left to right
      edges('{32'h00050000, 32'hFFFF0000, 32'h000A0000, 32'hFFFF0000, 32'h000D0000,
         32'h00010000, 32'h00100000, 32'h00020000, 32'h00010000});
      wr(`TSW_OFF_CNT, 32'h3);
      wr(`TSW_OFF_RENDER, 32'h0);
      wr(`TSW_OFF_DSL, 32'h00050000);
      settle;
      walk(3, 1'b0, 1'b0);
      cmpq("trapezoid");
      // right to left upward, knee handled by continue written while busy
      edges('{32'h00030000, 32'h00010000, 32'h00140000, 32'h0, 32'h00140000,
         32'hFFFE0000, 32'h00400000, 32'h0, 32'hFFFF0000});
      wr(`TSW_OFF_CNT, 32'h3);
      wr(`TSW_OFF_RENDER, 32'h0);
      wr(`TSW_OFF_SSX, 32'h000F0000);
      wr(`TSW_OFF_SSL, 32'h00010000);
      wr(`TSW_OFF_CONT, 32'h2);
      settle;
      walk(3, 1'b0, 1'b0);
      m[4] = 32'h000F0000;
      m[5] = 32'h00010000;
      walk(2, 1'b0, 1'b0);
      cmpq("continue");
      // depth pair, widths and centering, red in the upper colour byte
      wr(`TSW_OFF_MODE, 32'h00040404);
      wr(`TSW_OFF_ZSI, 32'h0001ABCD);
      wr(`TSW_OFF_ZSF, 32'h80000000);
      wr(`TSW_OFF_ZDYI, 32'h0);
      wr(`TSW_OFF_ZDYF, 32'h0);
      wr(`TSW_OFF_ZDXI, 32'h0);
      wr(`TSW_OFF_ZDXF, 32'h80000000);
      v = '{32'h00080000, 32'hFFFF0000, 32'h00020000, 32'h0, 32'h00040000,
         32'h0, 32'h00200000, 32'h0, 32'h00020000};
      edges(v);
      wr(`TSW_OFF_CNT, 32'h1);
      wr(`TSW_OFF_RENDER, 32'h00010000);
      settle;
      chk(dq[0], 32'h0000ABCD);
      chk(dq[1], 32'h0000ABCE);
      chk(lc, 1'b1);
      walk(1, 1'b1, 1'b1);
      cmpq("centered");
      wr(`TSW_OFF_MODE, 32'h00040000);
      edges(v);
      wr(`TSW_OFF_RENDER, 32'h0);
      settle;
      chk(dq[0], 32'h00002BCD);
      chk(dq[1], 32'h00002BCE);
      chk(lc, 1'b0);
      walk(1, 1'b1, 1'b0);
      cmpq("depth15");
      // culling by area sign, then repeat keeps the mode of its draw
      wr(`TSW_OFF_MODE, 32'h00060000);
      wr(`TSW_OFF_AREA, 32'hFFFFFFF0);
      edges(v);
      ni = 0;
      wr(`TSW_OFF_DRAW, 32'h00100000);
      settle;
      chk(64'(ni), 64'h0);
      chk(64'(fq.size()), 64'h0);
      rd(`TSW_OFF_STATUS);
      chk(rd_v[31:16], 16'h0001);
      wr(`TSW_OFF_DRAW, 32'h0);
      settle;
      chk(64'(ni), 64'h1);
      walk(1, 1'b1, 1'b0);
      cmpq("draw");
      wr(`TSW_OFF_MODE, 32'h0);
      edges(v);
      wr(`TSW_OFF_REPEAT, 32'h0);
      settle;
      walk(1, 1'b1, 1'b0);
      cmpq("repeat");
      test_done;
   end
endmodule // tsw_top_tb
